/* design/optical_sync_cfg.svh */
/*
 * Offsets, field positions, reset values and timing counts for the
 * optical sync pin control block.
 * Assumes inclusion by bare name from the package and the design file.
 */
`ifndef OPTICAL_SYNC_CFG_SVH
`define OPTICAL_SYNC_CFG_SVH

// register byte addresses
`define SYNC_CONTROL_ADDR 8'h10
`define SEQ_CONFIG_ADDR 8'h14
`define SEQ_STATUS_ADDR 8'h18
`define RESULT_ADDR 8'h1C
// sync_control fields
`define PINFN_LSB 0
`define PINFN_MSB 3
`define SYNC_CONTROL_RST 8'h00
// seq_config fields: three steps of 4 bits, ambient enable, run request
`define STEP_W 4
`define AMB_EN_BIT 12
`define RUN_BIT 13
`define SEQ_CONFIG_RST 14'h0000
// pin-function codes
`define PINFN_STANDALONE 4'h0
`define PINFN_EXTCLK 4'h1
`define PINFN_TRIG 4'h2
`define PINFN_TRIG_EXTCLK 4'h3
// step codes selecting muxed emitters four, five, six
`define STEP_MUX_FOUR 4'hA
`define STEP_MUX_FIVE 4'hB
`define STEP_MUX_SIX 4'hC
`define STEP_OFF 4'h0
// exposure length per slot in timing-clock ticks
`define SLOT_TICKS 4'h4
// internal oscillator tick divider: 250 MHz / 32768 Hz
`define OSC_HZ 32768
`define REF_HZ 250000000
`define OSC_DIV (`REF_HZ / `OSC_HZ)

`endif

/* design/optical_sync_pkg.sv */
/*
 * Types for the optical sync pin control block.
 * Assumes the _cfg header for its constants.
 */
`include "optical_sync_cfg.svh"
package optical_sync_pkg;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_AMB = 3'b001,
		ST_EXP = 3'b011,
		ST_WRITE = 3'b010,
		ST_AMBS = 3'b110
	} seq_state_e;
	typedef struct packed {
		logic [3:0] o;
		logic [3:0] oe;
	} pins_s;
	typedef struct packed {
		logic valid;
		logic [1:0] slot;
		logic ambient;
		logic [3:0] step;
	} result_s;
endpackage

/* design/optical_sync_pin_control.sv */
/*
 * Auxiliary pin role selection and exposure sequencer for an optical
 * sampling front end, with an AHB-Lite register slave.
 * Assumes one AHB-Lite master, and an external pull-up on the mux pins.
 */
// Our own choice: the AHB-Lite interface to the registers.
// What this block does
// - two sequential LEDs with ambient: results go LED one, LED two, ambient
// - three sequential LEDs with ambient: expose each, then one ambient sample
// - a 4-bit pin-function field in sync_control selects both pin roles
// - code 0000: pin one mux control, pin two off, internal oscillator
// - codes 0000-0010: mux pin low on emitters four-six, high otherwise
// - no muxed step configured: mux pin tristated, never driven
// - code 0001: pin two takes external 32 kHz clock for all timing
// - code 0010: pin one trigger input, pin two mux, internal exposure timing
// - code 0011: pin one trigger input, pin two external exposure clock
// - each exposure follows an ambient slot, but its result is not ambient corrected
`timescale 1ns/10ps
`default_nettype none
`include "optical_sync_cfg.svh"
module optical_sync_pin_control
	import optical_sync_pkg::*;
(
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic ext_clk,
	input wire logic aux_pin_one_i,
	output logic aux_pin_one_o,
	output logic aux_pin_one_oe,
	input wire logic aux_pin_two_i,
	output logic aux_pin_two_o,
	output logic aux_pin_two_oe,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic hsel,
	input wire logic hready,
	input wire logic [31:0] hwdata,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	output logic result_valid,
	output optical_sync_pkg::result_s result_out
);
	import optical_sync_pkg::*;

	function automatic logic is_muxed(input logic [3:0] s);
		is_muxed = (s == `STEP_MUX_FOUR) || (s == `STEP_MUX_FIVE) ||
			(s == `STEP_MUX_SIX);
	endfunction

	logic [7:0] sync_control_q;
	logic [13:0] seq_config_q;
	logic wr_pend_q;
	logic [7:0] wr_addr_q;
	seq_state_e state_q;
	logic [1:0] slot_q;
	logic [3:0] cur_step_q;
	logic [3:0] tick_cnt_q;
	logic [12:0] osc_cnt_q;
	logic osc_tick_q;
	logic [1:0] run_sync_q;
	logic ext_tgl_q;
	logic [2:0] tgl_sync_q;
	logic [2:0] trig_sync_q;
	logic trig_armed_q;
	logic clk_two_q;
	logic [1:0] busy_ext_sync_q;
	logic [3:0] amb_level_q;
	result_s res_q;
	pins_s pins_q;

	wire [3:0] pin_fn = sync_control_q[`PINFN_MSB:`PINFN_LSB];
	wire [3:0] step0 = seq_config_q[3:0];
	wire [3:0] step1 = seq_config_q[7:4];
	wire [3:0] step2 = seq_config_q[11:8];
	wire amb_en = seq_config_q[`AMB_EN_BIT];
	wire any_muxed = is_muxed(step0) | is_muxed(step1) | is_muxed(step2);
	wire trig_mode = (pin_fn == `PINFN_TRIG) ||
		(pin_fn == `PINFN_TRIG_EXTCLK);
	wire ext_timing = (pin_fn == `PINFN_EXTCLK) ||
		(pin_fn == `PINFN_TRIG_EXTCLK);
	wire busy = (state_q != ST_IDLE);

	// ahb-lite slave: zero wait states, writes land one cycle after address
	wire addr_ok = hsel & hready & htrans[1];
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			wr_pend_q <= 1'b0;
			wr_addr_q <= 8'h00;
		end else begin
			wr_pend_q <= addr_ok & hwrite;
			wr_addr_q <= haddr[7:0];
		end
	end

	// register storage; writes to unmapped addresses are dropped
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			sync_control_q <= `SYNC_CONTROL_RST;
			seq_config_q <= `SEQ_CONFIG_RST;
		end else if (wr_pend_q) begin
			if (wr_addr_q == `SYNC_CONTROL_ADDR)
				sync_control_q <= hwdata[7:0];
			if (wr_addr_q == `SEQ_CONFIG_ADDR)
				seq_config_q <= hwdata[13:0];
		end
	end

	// read data registered so hrdata comes straight from a flop
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			hrdata <= 32'h0000_0000;
		end else if (addr_ok & ~hwrite) begin
			unique case (haddr[7:0])
				`SYNC_CONTROL_ADDR: hrdata <= {24'h000000, sync_control_q};
				`SEQ_CONFIG_ADDR: hrdata <= {18'h00000, seq_config_q};
				`SEQ_STATUS_ADDR: hrdata <= {25'h0000000, state_q, slot_q,
					trig_armed_q, busy};
				`RESULT_ADDR: hrdata <= {24'h000000, res_q};
				default: hrdata <= 32'h0000_0000;
			endcase
		end
	end

	// always ready, always okay
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
	end

	// external 32 kHz clock domain: toggle per rising edge, only while external timing is selected;
	// no reset reaches here, so the clear while deselected also flushes power-up unknowns
	always_ff @(posedge ext_clk) begin
		busy_ext_sync_q <= {busy_ext_sync_q[0], ext_timing};
		if (busy_ext_sync_q[1])
			ext_tgl_q <= ~ext_tgl_q;
		else
			ext_tgl_q <= 1'b0;
	end

	// toggle crossing into ref_clk; only stage two onward is looked at
	always_ff @(posedge ref_clk) begin
		if (reset)
			tgl_sync_q <= 3'b000;
		else
			tgl_sync_q <= {tgl_sync_q[1:0], ext_tgl_q};
	end

	// internal oscillator tick at 32768 Hz
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			osc_cnt_q <= 13'h0000;
			osc_tick_q <= 1'b0;
		end else if (osc_cnt_q == 13'(`OSC_DIV - 1)) begin
			osc_cnt_q <= 13'h0000;
			osc_tick_q <= 1'b1;
		end else begin
			osc_cnt_q <= osc_cnt_q + 13'h0001;
			osc_tick_q <= 1'b0;
		end
	end

	// timing source: external clock in 0001 and 0011, else internal
	wire ext_tick = tgl_sync_q[2] ^ tgl_sync_q[1];
	wire tick = ext_timing ? ext_tick : osc_tick_q;

	// trigger pin synchroniser and rising edge detector
	always_ff @(posedge ref_clk) begin
		if (reset)
			trig_sync_q <= 3'b000;
		else
			trig_sync_q <= {trig_sync_q[1:0], aux_pin_one_i};
	end
	wire trig_rise = trig_sync_q[2] == 1'b0 && trig_sync_q[1] == 1'b1;

	// edges while busy are dropped, not queued
	always_ff @(posedge ref_clk) begin
		if (reset)
			trig_armed_q <= 1'b0;
		else
			trig_armed_q <= trig_mode & trig_rise & ~busy;
	end

	// stand-alone runs free on the run bit; trigger modes wait for an edge
	wire start = trig_mode ? trig_armed_q :
		(seq_config_q[`RUN_BIT] & ~busy);

	// ambient level captured per slot from the current step code; stands in for
	// the analogue cancellation, but nothing subtracts it from the result
	always_ff @(posedge ref_clk) begin
		if (reset)
			amb_level_q <= 4'h0;
		else if (state_q == ST_AMB && tick)
			amb_level_q <= cur_step_q;
	end

	function automatic logic [3:0] step_at(input logic [1:0] s,
		input logic [11:0] cfg);
		step_at = (s == 2'd0) ? cfg[3:0] : (s == 2'd1) ? cfg[7:4] :
			cfg[11:8];
	endfunction

	// sequencer: per slot ambient, exposure, write; then ambient slot if amb_en is set
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			state_q <= ST_IDLE;
			slot_q <= 2'd0;
			cur_step_q <= `STEP_OFF;
			tick_cnt_q <= 4'h0;
			res_q <= '0;
		end else begin
			res_q.valid <= 1'b0;
			unique case (state_q)
				ST_IDLE: if (start && step0 != `STEP_OFF) begin
					state_q <= ST_AMB;
					slot_q <= 2'd0;
					cur_step_q <= step0;
					tick_cnt_q <= 4'h0;
				end
				ST_AMB: if (tick) begin
					state_q <= ST_EXP;
				end
				ST_EXP: if (tick) begin
					if (tick_cnt_q == `SLOT_TICKS - 4'h1) begin
						tick_cnt_q <= 4'h0;
						state_q <= ST_WRITE;
					end else
						tick_cnt_q <= tick_cnt_q + 4'h1;
				end
				ST_WRITE: begin
					res_q <= '{valid: 1'b1, slot: slot_q, ambient: 1'b0,
						step: cur_step_q};
					if (slot_q != 2'd2 &&
						step_at(slot_q + 2'd1, seq_config_q[11:0]) != `STEP_OFF)
					begin
						slot_q <= slot_q + 2'd1;
						cur_step_q <= step_at(slot_q + 2'd1, seq_config_q[11:0]);
						state_q <= ST_AMB;
					end else if (amb_en) begin
						cur_step_q <= `STEP_OFF;
						state_q <= ST_AMBS;
					end else begin
						cur_step_q <= `STEP_OFF;
						state_q <= ST_IDLE;
					end
				end
				ST_AMBS: if (tick) begin
					res_q <= '{valid: 1'b1, slot: slot_q, ambient: 1'b1,
						step: `STEP_OFF};
					state_q <= ST_IDLE;
				end
				default: state_q <= ST_IDLE;
			endcase
		end
	end

	// pin roles; mux pin drives only when a muxed step is configured
	wire mux_level = ~(state_q == ST_EXP && is_muxed(cur_step_q));
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			pins_q <= '0;
		end else begin
			pins_q <= '0;
			unique case (pin_fn)
				`PINFN_STANDALONE, `PINFN_EXTCLK: begin
					pins_q.o[0] <= mux_level;
					pins_q.oe[0] <= any_muxed;
				end
				`PINFN_TRIG: begin
					pins_q.o[1] <= mux_level;
					pins_q.oe[1] <= any_muxed;
				end
				default: pins_q <= '0; // 0011 and unsupported: all inputs
			endcase
		end
	end

	assign aux_pin_one_o = pins_q.o[0];
	assign aux_pin_one_oe = pins_q.oe[0];
	assign aux_pin_two_o = pins_q.o[1];
	assign aux_pin_two_oe = pins_q.oe[1];
	assign result_valid = res_q.valid;
	assign result_out = res_q;

	// pin two input is never used; the external clock arrives on ext_clk
	wire unused_pin_two = aux_pin_two_i;
	always_ff @(posedge ref_clk) clk_two_q <= unused_pin_two & 1'b0;

	property p_mux_low_on_muxed;
		@(posedge ref_clk) disable iff (reset)
		(state_q == ST_EXP && is_muxed(cur_step_q) &&
			(pin_fn == `PINFN_STANDALONE || pin_fn == `PINFN_EXTCLK) &&
			any_muxed) |=> (aux_pin_one_o == 1'b0 && aux_pin_one_oe);
	endproperty
	a_mux_low_on_muxed: assert property (p_mux_low_on_muxed)
		else $error("mux pin not low on muxed exposure");

	property p_tristate_no_mux;
		@(posedge ref_clk) disable iff (reset)
		!any_muxed |=> !aux_pin_one_oe && !aux_pin_two_oe;
	endproperty
	a_tristate_no_mux: assert property (p_tristate_no_mux)
		else $error("mux pin driven without muxed step");

	property p_trig_no_one_drive;
		@(posedge ref_clk) disable iff (reset)
		trig_mode |=> !aux_pin_one_oe;
	endproperty
	a_trig_no_one_drive: assert property (p_trig_no_one_drive)
		else $error("trigger pin driven");

	property p_extclk_no_two_drive;
		@(posedge ref_clk) disable iff (reset)
		ext_timing |=> !aux_pin_two_oe;
	endproperty
	a_extclk_no_two_drive: assert property (p_extclk_no_two_drive)
		else $error("clock pin driven");

	property p_ambient_last;
		@(posedge ref_clk) disable iff (reset)
		(res_q.valid && res_q.ambient) |-> state_q == ST_IDLE;
	endproperty
	a_ambient_last: assert property (p_ambient_last)
		else $error("ambient not last");

	property p_busy_ignored;
		@(posedge ref_clk) disable iff (reset)
		busy |=> !trig_armed_q;
	endproperty
	a_busy_ignored: assert property (p_busy_ignored)
		else $error("trigger accepted while busy");

	property p_amb_before_exp;
		@(posedge ref_clk) disable iff (reset)
		(state_q == ST_EXP && $past(state_q) != ST_EXP) |->
			$past(state_q) == ST_AMB;
	endproperty
	a_amb_before_exp: assert property (p_amb_before_exp)
		else $error("exposure without ambient");

	property p_fn_field;
		@(posedge ref_clk) disable iff (reset)
		(wr_pend_q && wr_addr_q == 8'h10) |=>
			pin_fn == $past(hwdata[3:0]);
	endproperty
	a_fn_field: assert property (p_fn_field)
		else $error("pin-function field not stored");
endmodule // optical_sync_pin_control
`default_nettype wire

/* sim/far_side_model.sv */
/*
 * Far side of the aux pins: a free-running 8 MHz stand-in clock source,
 * a master sensor trigger, and the wire levels on both pins.
 * Assumes the bench raises trig_req by NBA just after a ref_clk edge.
 */
`timescale 1ns/10ps
`default_nettype none
module far_side_model (
	input wire logic trig_req,
	input wire logic one_o,
	input wire logic one_oe,
	input wire logic two_o,
	input wire logic two_oe,
	output logic ext_clk,
	output logic trig,
	output wire logic one_wire,
	output wire logic two_wire
);
	// rtc source runs free, phase unrelated to ref_clk
	initial begin
		ext_clk = 1'b0;
		#37;
		forever #62.5 ext_clk = ~ext_clk;
	end
	// master sample output lags the request slightly
	assign #3 trig = trig_req;
	// device wins the wire only while it enables its driver
	assign one_wire = one_oe ? one_o : trig;
	assign two_wire = two_oe ? two_o : ext_clk;
endmodule // far_side_model
`default_nettype wire

/* sim/testbench.sv */
/*
 * Self-checking bench: AHB-Lite register access and trigger driven
 * sequences. Assumes the far side model supplies clock and trigger.
 */
`timescale 1ns/10ps
`default_nettype none
`include "optical_sync_cfg.svh"
module testbench;
	import optical_sync_pkg::*;
	localparam logic [31:0] sync_a = {24'h000000, `SYNC_CONTROL_ADDR};
	localparam logic [31:0] seq_a = {24'h000000, `SEQ_CONFIG_ADDR};
	logic ref_clk, reset, hwrite, hsel, hreadyout, hresp, result_valid;
	logic trig_req, ext_clk, trig, one_o, one_oe, two_o, two_oe;
	wire logic one_w, two_w;
	logic [31:0] haddr, hwdata, hrdata, rv;
	logic [1:0] htrans;
	logic [2:0] hsize;
	result_s result_out;
	int miscompares, checked, low_cnt;
	logic [4:0] seen[$];

	optical_sync_pin_control optical_sync_pin_control_inst (
		.ref_clk(ref_clk), .reset(reset), .ext_clk(ext_clk),
		.aux_pin_one_i(one_w), .aux_pin_one_o(one_o),
		.aux_pin_one_oe(one_oe), .aux_pin_two_i(two_w),
		.aux_pin_two_o(two_o), .aux_pin_two_oe(two_oe),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hsel(hsel), .hready(hreadyout), .hwdata(hwdata),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.result_valid(result_valid), .result_out(result_out));

	far_side_model far_side_model_inst (
		.trig_req(trig_req), .one_o(one_o), .one_oe(one_oe),
		.two_o(two_o), .two_oe(two_oe), .ext_clk(ext_clk), .trig(trig),
		.one_wire(one_w), .two_wire(two_w));

	initial begin
		ref_clk = 1'b0;
		forever #2 ref_clk = ~ref_clk;
	end

	// results and mux low time; ambient folded to one code
	always @(posedge ref_clk) begin
		if (result_valid === 1'b1)
			seen.push_back(result_out.ambient ? 5'h10 : {1'b0, result_out.step});
		if (one_oe === 1'b1 && one_o === 1'b0)
			low_cnt++;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			miscompares++;
			$display("ERROR at %0t: seen %0h expected %0h", $time, got, exp);
		end
	endtask

	// one single word transfer; hold each phase until hready
	task automatic bus(input logic wr, input logic [31:0] a, d);
		@(posedge ref_clk);
		haddr <= a;
		hwrite <= wr;
		htrans <= 2'b10;
		hsel <= 1'b1;
		do @(posedge ref_clk); while (hreadyout !== 1'b1);
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge ref_clk); while (hreadyout !== 1'b1);
		rv = hrdata;
		hsel <= 1'b0;
		repeat (4) @(posedge ref_clk);
	endtask

	task automatic fire;
		trig_req <= 1'b1;
		repeat (8) @(posedge ref_clk);
		trig_req <= 1'b0;
		repeat (20) @(posedge ref_clk);
	endtask

	// wait for n results, then a quiet span to catch extra ones
	task automatic collect(input int n, input logic [4:0] e0, e1, e2, e3);
		logic [4:0] e[4];
		int k;
		e = '{e0, e1, e2, e3};
		k = 0;
		while (seen.size() < n && k < 4000) begin
			@(posedge ref_clk);
			k++;
		end
		repeat (400) @(posedge ref_clk);
		chk(seen.size(), n);
		for (int i = 0; i < n && i < seen.size(); i++)
			chk(seen[i], e[i]);
		seen.delete();
	endtask

	task automatic report_and_stop;
		$display("compares %0d mismatches %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	// whole run is near 3.5k cycles; this is ample headroom
	initial begin
		repeat (60000) @(posedge ref_clk);
		miscompares++;
		report_and_stop();
	end

	initial begin
		{reset, hwrite, hsel, trig_req} = 4'h8;
		{haddr, hwdata} = 64'h0;
		htrans = 2'b00;
		hsize = 3'b010;
		repeat (20) @(posedge ref_clk);
		reset <= 1'b0;
		bus(1'b0, sync_a, 32'h0);
		chk(rv, 32'h0);
		bus(1'b1, sync_a, 32'h3);
		bus(1'b0, sync_a, 32'h0);
		chk(rv, 32'h3);
		bus(1'b0, 32'h40, 32'h0);
		chk(rv, 32'h0);
		chk({one_oe, two_oe}, 2'b00);
		$display("test registers done");
		bus(1'b1, seq_a, 32'h1021);
		fire();
		collect(3, 5'h01, 5'h02, 5'h10, 5'h00);
		bus(1'b1, seq_a, 32'h1321);
		fire();
		fire();
		collect(4, 5'h01, 5'h02, 5'h03, 5'h10);
		bus(1'b0, {24'h000000, `RESULT_ADDR}, 32'h0);
		chk(rv, 32'h0000_0050);
		chk(hresp, 1'b0);
		$display("test triggered sequences done");
		bus(1'b1, sync_a, 32'h1);
		bus(1'b1, seq_a, 32'h201A);
		repeat (1200) @(posedge ref_clk);
		chk(low_cnt > 0, 1'b1);
		chk(seen.size() >= 2, 1'b1);
		chk(two_oe, 1'b0);
		bus(1'b1, seq_a, 32'h001A);
		repeat (400) @(posedge ref_clk);
		seen.delete();
		chk({one_oe, one_o}, 2'b11);
		$display("test external clock done");
		bus(1'b1, sync_a, 32'h0);
		chk({one_oe, one_o, two_oe}, 3'b110);
		bus(1'b1, seq_a, 32'h0001);
		chk(one_oe, 1'b0);
		bus(1'b1, sync_a, 32'h2);
		bus(1'b1, seq_a, 32'h000B);
		chk({one_oe, two_oe, two_o}, 3'b011);
		$display("test pin roles done");
		report_and_stop();
	end
endmodule // testbench
`default_nettype wire
